// ===== rtl/pstb_bank.sv
// Read-only status and telemetry command bank with byte-stream answers
`include "pstb_regs.svh"
`default_nettype none

module pstb_bank #(
  parameter int NUM_OUTPUTS = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire pstb_pkg::pstb_cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic rsp_error,
  input wire logic rsp_ready,
  input wire logic clear_faults,
  input wire pstb_pkg::pstb_thermal_evt_t thermal_evt,
  input wire pstb_pkg::pstb_comm_evt_t comm_evt,
  input wire logic otp_full,
  input wire logic meas_strobe,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] iin_meas,
  input wire logic [NUM_OUTPUTS*16-1:0] vout_meas,
  input wire logic [NUM_OUTPUTS*16-1:0] iout_meas,
  input wire logic [NUM_OUTPUTS*16-1:0] temp_meas,
  output logic status_word_temp,
  output logic status_word_comm
);

  localparam int PAGE_W = (NUM_OUTPUTS > 1) ? $clog2(NUM_OUTPUTS) : 1;
  localparam logic [3:0] PAGE_LIMIT = 4'(NUM_OUTPUTS);

  generate
    if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 15) begin : g_bad
      $error("pstb_bank serves between 1 and 15 outputs");
    end
  endgenerate

  // ************************************************************
  // Sticky fault summaries
  // ************************************************************
  logic [2:0] thermal_set;
  logic [2:0] thermal_q;
  logic [6:0] comm_set;
  logic [6:0] comm_q;
  logic own_bad_cmd;
  logic own_bad_data;

  // Fault and warning latch on their own bits, so a warning is kept after its event ends; clear_faults clears both
  assign thermal_set = {thermal_evt.ot_fault, thermal_evt.ot_warn,
                        thermal_evt.ut_fault};

  assign comm_set = {comm_evt.bad_cmd | own_bad_cmd,
                     comm_evt.bad_data | own_bad_data,
                     comm_evt.pec_err,
                     comm_evt.mem_fault, comm_evt.cpu_fault,
                     comm_evt.other_comm,
                     comm_evt.other_logic};

  pstb_sticky #(
    .WIDTH(3)
  ) u_thermal (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .set(thermal_set),
    .clr(clear_faults),
    .q(thermal_q)
  );

  pstb_sticky #(
    .WIDTH(7)
  ) u_comm (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .set(comm_set),
    .clr(clear_faults),
    .q(comm_q)
  );

  // ************************************************************
  // Summary bytes as answered
  // ************************************************************
  logic [7:0] thermal_byte;
  logic [7:0] comm_byte;
  logic [7:0] vendor_byte;
  logic otp_full_q;
  logic next_otp_full;

  always_comb begin
    thermal_byte = `PSTB_STATUS_RST;
    thermal_byte[`PSTB_TS_OT_FAULT] = thermal_q[2];
    thermal_byte[`PSTB_TS_OT_WARN] = thermal_q[1];
    thermal_byte[`PSTB_TS_UT_FAULT] = thermal_q[0];
  end

  always_comb begin
    comm_byte = `PSTB_STATUS_RST;
    comm_byte[`PSTB_CS_BAD_CMD] = comm_q[6];
    comm_byte[`PSTB_CS_BAD_DATA] = comm_q[5];
    comm_byte[`PSTB_CS_PEC_ERR] = comm_q[4];
    comm_byte[`PSTB_CS_MEM_FAULT] = comm_q[3];
    comm_byte[`PSTB_CS_CPU_FAULT] = comm_q[2];
    comm_byte[`PSTB_CS_OTHER_COMM] = comm_q[1];
    comm_byte[`PSTB_CS_OTHER_LOGIC] = comm_q[0];
  end

  // Store-full is a state of the store, not an event, so it follows the input
  always_comb begin
    next_otp_full = otp_full;
    vendor_byte = `PSTB_STATUS_RST;
    vendor_byte[`PSTB_VS_OTP_FULL] = otp_full_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_full_q <= 1'b0;
    end else begin
      otp_full_q <= next_otp_full;
    end
  end

  // ************************************************************
  // Status word summary bits
  // ************************************************************
  logic next_status_word_temp;
  logic next_status_word_comm;

  always_comb begin
    next_status_word_temp = |thermal_q;
    next_status_word_comm = |comm_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_word_temp <= 1'b0;
      status_word_comm <= 1'b0;
    end else begin
      status_word_temp <= next_status_word_temp;
      status_word_comm <= next_status_word_comm;
    end
  end

  // ************************************************************
  // Telemetry holding registers
  // ************************************************************
  // Snapshots keep both bytes of a word from one conversion
  logic [15:0] vin_q;
  logic [15:0] iin_q;
  logic [15:0] vout_mem [NUM_OUTPUTS];
  logic [15:0] iout_mem [NUM_OUTPUTS];
  logic [15:0] temp_mem [NUM_OUTPUTS];
  logic [15:0] next_vin;
  logic [15:0] next_iin;
  logic [15:0] next_vout [NUM_OUTPUTS];
  logic [15:0] next_iout [NUM_OUTPUTS];
  logic [15:0] next_temp [NUM_OUTPUTS];

  always_comb begin
    next_vin = meas_strobe ? vin_meas : vin_q;
    next_iin = meas_strobe ? iin_meas : iin_q;
    for (int p = 0; p < NUM_OUTPUTS; p++) begin
      next_vout[p] = meas_strobe ? vout_meas[p*16 +: 16] : vout_mem[p];
      next_iout[p] = meas_strobe ? iout_meas[p*16 +: 16] : iout_mem[p];
      next_temp[p] = meas_strobe ? temp_meas[p*16 +: 16] : temp_mem[p];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vin_q <= `PSTB_READ_RST;
      iin_q <= `PSTB_READ_RST;
      for (int p = 0; p < NUM_OUTPUTS; p++) begin
        vout_mem[p] <= `PSTB_READ_RST;
        iout_mem[p] <= `PSTB_READ_RST;
        temp_mem[p] <= `PSTB_READ_RST;
      end
    end else begin
      vin_q <= next_vin;
      iin_q <= next_iin;
      for (int p = 0; p < NUM_OUTPUTS; p++) begin
        vout_mem[p] <= next_vout[p];
        iout_mem[p] <= next_iout[p];
        temp_mem[p] <= next_temp[p];
      end
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************
  logic [15:0] dec_word;
  logic dec_is_word;
  logic dec_known;
  logic dec_paged;
  logic page_ok;
  logic [PAGE_W-1:0] page_idx;

  always_comb begin
    page_ok = cmd.page < PAGE_LIMIT;
    page_idx = page_ok ? cmd.page[PAGE_W-1:0] : '0;
    dec_word = `PSTB_READ_RST;
    dec_is_word = 1'b0;
    dec_known = 1'b1;
    dec_paged = 1'b0;
    case (cmd.code)
      `PSTB_CMD_THERMAL_SUM: begin
        dec_word = {8'h00, thermal_byte};
      end
      `PSTB_CMD_COMM_SUM: begin
        dec_word = {8'h00, comm_byte};
      end
      `PSTB_CMD_VENDOR_SUM: begin
        dec_word = {8'h00, vendor_byte};
      end
      `PSTB_CMD_VIN: begin
        dec_word = vin_q;
        dec_is_word = 1'b1;
      end
      `PSTB_CMD_IIN: begin
        dec_word = iin_q;
        dec_is_word = 1'b1;
      end
      `PSTB_CMD_VOUT: begin
        dec_word = vout_mem[page_idx];
        dec_is_word = 1'b1;
        dec_paged = 1'b1;
      end
      `PSTB_CMD_IOUT: begin
        dec_word = iout_mem[page_idx];
        dec_is_word = 1'b1;
        dec_paged = 1'b1;
      end
      `PSTB_CMD_TEMP: begin
        dec_word = temp_mem[page_idx];
        dec_is_word = 1'b1;
        dec_paged = 1'b1;
      end
      default: begin
        dec_known = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Answer sequencer
  // ************************************************************
  pstb_pkg::pstb_state_t state;
  pstb_pkg::pstb_state_t next_state;
  logic [7:0] high_q;
  logic [7:0] next_high;
  logic next_cmd_ready;
  logic next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic next_rsp_last;
  logic next_rsp_error;
  logic take;
  logic bad_request;

  assign take = cmd_valid & cmd_ready;
  // A write is refused and touches no stored value but the bad-command sticky bit
  assign bad_request = cmd.write | ~dec_known | (dec_paged & ~page_ok);
  assign own_bad_cmd = take & (cmd.write | ~dec_known);
  assign own_bad_data = take & ~cmd.write & dec_known & dec_paged & ~page_ok;

  always_comb begin
    next_state = state;
    next_high = high_q;
    next_rsp_valid = rsp_valid;
    next_rsp_data = rsp_data;
    next_rsp_last = rsp_last;
    next_rsp_error = rsp_error;
    case (state)
      pstb_pkg::PSTB_IDLE: begin
        if (take) begin
          next_state = pstb_pkg::PSTB_LOW;
          next_rsp_valid = 1'b1;
          if (bad_request) begin
            next_rsp_data = `PSTB_ERR_BYTE;
            next_rsp_last = 1'b1;
            next_rsp_error = 1'b1;
            next_high = 8'h00;
          end else begin
            // Low byte goes first; the high byte waits in high_q
            next_rsp_data = dec_word[7:0];
            next_rsp_last = ~dec_is_word;
            next_rsp_error = 1'b0;
            next_high = dec_word[15:8];
          end
        end
      end
      pstb_pkg::PSTB_LOW: begin
        if (rsp_ready) begin
          if (rsp_last) begin
            next_state = pstb_pkg::PSTB_IDLE;
            next_rsp_valid = 1'b0;
            next_rsp_last = 1'b0;
            next_rsp_error = 1'b0;
            next_rsp_data = 8'h00;
          end else begin
            next_state = pstb_pkg::PSTB_HIGH;
            next_rsp_data = high_q;
            next_rsp_last = 1'b1;
          end
        end
      end
      pstb_pkg::PSTB_HIGH: begin
        if (rsp_ready) begin
          next_state = pstb_pkg::PSTB_IDLE;
          next_rsp_valid = 1'b0;
          next_rsp_last = 1'b0;
          next_rsp_data = 8'h00;
        end
      end
      default: begin
        next_state = pstb_pkg::PSTB_IDLE;
        next_rsp_valid = 1'b0;
        next_rsp_last = 1'b0;
        next_rsp_error = 1'b0;
        next_rsp_data = 8'h00;
      end
    endcase
    next_cmd_ready = next_state == pstb_pkg::PSTB_IDLE;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= pstb_pkg::PSTB_IDLE;
      high_q <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_last <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      state <= next_state;
      high_q <= next_high;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_last <= next_rsp_last;
      rsp_error <= next_rsp_error;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pstb_regs.svh
// Command codes, bit positions and reset values of the status/telemetry bank
`ifndef PSTB_REGS_SVH
`define PSTB_REGS_SVH

// ************************************************************
// Command codes
// ************************************************************
`define PSTB_CMD_THERMAL_SUM 8'h7D
`define PSTB_CMD_COMM_SUM 8'h7E
`define PSTB_CMD_VENDOR_SUM 8'h80
`define PSTB_CMD_VIN 8'h88
`define PSTB_CMD_IIN 8'h89
`define PSTB_CMD_VOUT 8'h8B
`define PSTB_CMD_IOUT 8'h8C
`define PSTB_CMD_TEMP 8'h8D

// ************************************************************
// Thermal summary bit positions
// ************************************************************
`define PSTB_TS_OT_FAULT 7
`define PSTB_TS_OT_WARN 6
`define PSTB_TS_UT_FAULT 4

// ************************************************************
// Communication/logic summary bit positions
// ************************************************************
`define PSTB_CS_BAD_CMD 7
`define PSTB_CS_BAD_DATA 6
`define PSTB_CS_PEC_ERR 5
`define PSTB_CS_MEM_FAULT 4
`define PSTB_CS_CPU_FAULT 3
`define PSTB_CS_OTHER_COMM 1
`define PSTB_CS_OTHER_LOGIC 0

// ************************************************************
// Vendor summary and status word bit positions
// ************************************************************
`define PSTB_VS_OTP_FULL 1
`define PSTB_SW_TEMPERATURE 2
`define PSTB_SW_COMM 1

// ************************************************************
// Reset values
// ************************************************************
`define PSTB_STATUS_RST 8'h00
`define PSTB_READ_RST 16'h0000
`define PSTB_ERR_BYTE 8'h00

`endif

// ===== rtl/pstb_pkg.sv
// Types shared by the status/telemetry bank modules
`default_nettype none

package pstb_pkg;

  // Command as handed over by the bus transport
  typedef struct packed {
    logic [7:0] code;
    logic write;
    logic [3:0] page;
  } pstb_cmd_t;

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic ut_fault;
  } pstb_thermal_evt_t;

  typedef struct packed {
    logic bad_cmd;
    logic bad_data;
    logic pec_err;
    logic mem_fault;
    logic cpu_fault;
    logic other_comm;
    logic other_logic;
  } pstb_comm_evt_t;

  typedef enum logic [1:0] {
    PSTB_IDLE,
    PSTB_LOW,
    PSTB_HIGH
  } pstb_state_t;

endpackage

`default_nettype wire

// ===== rtl/pstb_sticky.sv
// Vector of sticky status bits: set by events, cleared together, set wins
`default_nettype none

module pstb_sticky #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] set,
  input wire logic clr,
  output logic [WIDTH-1:0] q
);

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pstb_sticky needs WIDTH of at least 1");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic next_q;
      // An event in the clearing cycle survives the clear
      always_comb begin
        next_q = set[i] | (q[i] & ~clr);
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          q[i] <= 1'b0;
        end else begin
          q[i] <= next_q;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== sim/pstb_bank_chk.sv
// Concurrent checks on the ports of the status and telemetry bank
`default_nettype none

module pstb_bank_chk #(
  parameter int NUM_OUTPUTS = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire pstb_pkg::pstb_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_error,
  input wire logic rsp_ready,
  input wire pstb_pkg::pstb_thermal_evt_t thermal_evt,
  input wire pstb_pkg::pstb_comm_evt_t comm_evt,
  input wire logic status_word_temp,
  input wire logic status_word_comm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cur_code;
  logic take;
  assign take = cmd_valid && cmd_ready;
  // Code of the command whose answer is on the port
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_code <= 8'h00;
    end else if (take) begin
      cur_code <= cmd.code;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Assertions
  // ****************************************
  AST_TAKE_ANSWER: assert property (take |=> rsp_valid && !cmd_ready)
    else $error("no answer byte after a taken command");
  AST_BYTE_HOLD: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data))
    else $error("answer byte changed while stalled");
  AST_ONE_BYTE: assert property (take && cmd.code inside {8'h7D, 8'h7E, 8'h80} |=>
      rsp_last)
    else $error("status answer is not a single byte");
  AST_WORD_FIRST: assert property (take && !cmd.write && cmd.code == 8'h88 |=> !rsp_last)
    else $error("word answer ended on its first byte");
  AST_REFUSE_WRITE: assert property (take && cmd.write |=> rsp_error && rsp_data == 8'h00)
    else $error("write attempt not refused");
  AST_PAGE_RANGE: assert property (take && cmd.code inside {8'h8B, 8'h8C, 8'h8D} &&
      cmd.page >= NUM_OUTPUTS |=> rsp_error && rsp_last)
    else $error("page beyond the outputs not refused");
  AST_THERM_UNUSED: assert property (rsp_valid && cur_code == 8'h7D |->
      !rsp_data[5] && rsp_data[3:0] == 4'h0)
    else $error("unused thermal bit set");
  AST_COMM_UNUSED: assert property (rsp_valid && cur_code == 8'h7E |-> !rsp_data[2])
    else $error("unused comm bit set");
  AST_VENDOR_UNUSED: assert property (rsp_valid && cur_code == 8'h80 |->
      (rsp_data & 8'hFD) == 8'h00)
    else $error("unused vendor bit set");
  AST_SW_TEMP: assert property (thermal_evt != 3'h0 |-> ##2 status_word_temp)
    else $error("thermal event missing from status word");
  AST_SW_COMM: assert property (comm_evt != 7'h00 |-> ##2 status_word_comm)
    else $error("comm event missing from status word");
endmodule

bind pstb_bank pstb_bank_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk_u (.mclk, .sys_rst, .cmd_valid,
  .cmd, .cmd_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_error, .rsp_ready, .thermal_evt,
  .comm_evt, .status_word_temp, .status_word_comm);

`default_nettype wire

// ===== sim/pstb_host.sv
// Host model issuing read and write commands and collecting answer bytes
`default_nettype none

module pstb_host (
  input wire logic mclk,
  input wire logic slow,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_error,
  output logic cmd_valid,
  output pstb_pkg::pstb_cmd_t cmd,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    rsp_ready = 1'b0;
  end
  // Bytes come low first; a slow host stalls two cycles before each byte
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [3:0] page,
                      output logic [15:0] val, output logic err);
    int n;
    int stall;
    logic done;
    n = 0;
    stall = 0;
    done = 1'b0;
    val = 16'h0000;
    err = 1'b0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = '{code: code, write: wr, page: page};
    while (!cmd_ready) @(negedge mclk);
    while (!done) begin
      @(negedge mclk);
      if (cmd_valid) begin
        cmd_valid = 1'b0;
        cmd = ~cmd;
      end
      if (!rsp_valid || (slow && stall < 2)) begin
        rsp_ready = 1'b0;
        stall = stall + 1;
      end else begin
        rsp_ready = 1'b1;
        val[8*n +: 8] = rsp_data;
        err = rsp_error;
        done = rsp_last;
        n = n + 1;
        stall = 0;
      end
    end
    @(negedge mclk);
    rsp_ready = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_pstb_bank.sv
// Self-checking bench for the status and telemetry bank
`default_nettype none

module tb_pstb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_error, rsp_ready;
  logic clear_faults, otp_full, meas_strobe, status_word_temp, status_word_comm, host_slow;
  logic gerr;
  logic [7:0] rsp_data;
  logic [15:0] vin_meas, iin_meas, vin_e, iin_e, got;
  logic [31:0] vout_meas, iout_meas, temp_meas, vout_e, iout_e, temp_e;
  pstb_pkg::pstb_cmd_t cmd;
  pstb_pkg::pstb_thermal_evt_t thermal_evt;
  pstb_pkg::pstb_comm_evt_t comm_evt;
  int bad_count, cmp_count, cyc;
  integer seed;

  pstb_bank #(.NUM_OUTPUTS(2)) dut_u (.mclk, .sys_rst, .cmd_valid, .cmd, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_last, .rsp_error, .rsp_ready, .clear_faults, .thermal_evt,
    .comm_evt, .otp_full, .meas_strobe, .vin_meas, .iin_meas, .vout_meas, .iout_meas,
    .temp_meas, .status_word_temp, .status_word_comm);
  pstb_host host_u (.mclk, .slow(host_slow), .cmd_ready, .rsp_valid, .rsp_data, .rsp_last,
    .rsp_error, .cmd_valid, .cmd, .rsp_ready);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Cuts a hang well beyond the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  function automatic logic [7:0] therm_exp(int i);
    return (i == 3) ? 8'hD0 : (8'h10 << ((i == 0) ? 0 : i + 1));
  endfunction
  function automatic logic [7:0] comm_exp(int i);
    return 8'h01 << ((i < 2) ? i : i + 1);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic wr, input logic [3:0] pg,
                    input logic [15:0] exp, input logic experr);
    host_u.xfer(code, wr, pg, got, gerr);
    chk(got, exp);
    chk({15'h0000, gerr}, {15'h0000, experr});
  endtask
  task automatic pulse(input logic [2:0] t, input logic [6:0] c, input logic clr);
    @(negedge mclk);
    thermal_evt = t;
    comm_evt = c;
    clear_faults = clr;
    @(negedge mclk);
    thermal_evt = '0;
    comm_evt = '0;
    clear_faults = 1'b0;
  endtask
  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h42f5;
    {bad_count, cmp_count, cyc} = '0;
    {clear_faults, otp_full, meas_strobe, host_slow} = '0;
    {vin_meas, iin_meas, vout_meas, iout_meas, temp_meas} = '0;
    thermal_evt = '0;
    comm_evt = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    rd(8'h7D, 0, 0, 16'h0000, 0);
    rd(8'h7E, 0, 0, 16'h0000, 0);
    rd(8'h80, 0, 0, 16'h0000, 0);
    rd(8'h8D, 0, 1, 16'h0000, 0);
    // Inputs are inverted after the strobe so only the snapshot can match
    for (int r = 0; r < 4; r++) begin
      vin_e = (r == 0) ? 16'h8000 : 16'($random(seed));
      iin_e = (r == 0) ? 16'h7FFF : 16'($random(seed));
      vout_e = $random(seed);
      iout_e = $random(seed);
      temp_e = (r == 0) ? 32'hFFFF_0000 : $random(seed);
      {vin_meas, iin_meas, vout_meas, iout_meas, temp_meas} =
        {vin_e, iin_e, vout_e, iout_e, temp_e};
      meas_strobe = 1'b1;
      @(negedge mclk);
      meas_strobe = 1'b0;
      {vin_meas, iin_meas, vout_meas, iout_meas, temp_meas} =
        ~{vin_e, iin_e, vout_e, iout_e, temp_e};
      host_slow = 1'($random(seed));
      rd(8'h88, 0, 0, vin_e, 0);
      rd(8'h89, 0, 0, iin_e, 0);
      for (int p = 0; p < 2; p++) begin
        rd(8'h8B, 0, 4'(p), vout_e[p*16 +: 16], 0);
        rd(8'h8C, 0, 4'(p), iout_e[p*16 +: 16], 0);
        rd(8'h8D, 0, 4'(p), temp_e[p*16 +: 16], 0);
      end
    end
    for (int i = 0; i < 4; i++) begin
      pulse(3'h0, 7'h00, 1'b1);
      pulse((i == 3) ? 3'h7 : 3'h1 << i, 7'h00, 1'b0);
      @(negedge mclk);
      chk({15'h0000, status_word_temp}, 16'h0001);
      rd(8'h7D, 0, 0, {8'h00, therm_exp(i)}, 0);
    end
    for (int i = 0; i < 7; i++) begin
      pulse(3'h0, 7'h00, 1'b1);
      @(negedge mclk);
      chk({14'h0000, status_word_temp, status_word_comm}, 16'h0000);
      pulse(3'h0, 7'h01 << i, 1'b0);
      // The status word lags the sticky bit by one more edge
      @(negedge mclk);
      chk({15'h0000, status_word_comm}, 16'h0001);
      rd(8'h7E, 0, 0, {8'h00, comm_exp(i)}, 0);
    end
    for (int k = 0; k < 3; k++) begin
      pulse(3'h0, 7'h00, 1'b1);
      rd((k == 0) ? 8'h7D : (k == 1) ? 8'h79 : 8'h8B, k == 0, 4'(k), 16'h0000, 1);
      rd(8'h7E, 0, 0, (k == 2) ? 16'h0040 : 16'h0080, 0);
    end
    otp_full = 1'b1;
    rd(8'h80, 0, 0, 16'h0002, 0);
    otp_full = 1'b0;
    rd(8'h80, 0, 0, 16'h0000, 0);
    report_and_stop();
  end
endmodule

`default_nettype wire
